// [rtl/bridge_ms_cfg.svh]
// Offsets, field positions, reset values and timing counts of the readout block
`ifndef BRIDGE_MS_CFG_SVH
`define BRIDGE_MS_CFG_SVH
`define ADR_FLAGS   8'h00
`define ADR_SMP1    8'h04
`define ADR_SMP10   8'h28
`define ADR_RANGE   8'h2c
`define ADR_PERIOD  8'h30
`define ADR_COUNT   8'h34
`define ADR_IRQ_ST  8'h38
`define ADR_IRQ_MSK 8'h3c
`define BIT_INVALID 0
`define BIT_OPEN    1
`define BIT_NSYNC   2
`define RANGE_RST   8'h00
`define PERIOD_RST  8'h00
`define COUNT_RST   4'ha
`define COUNT_MIN   4'h3
`define COUNT_MAX   4'ha
`define PER_50US    8'h00
`define PER_100US   8'h01
`define CLK_NS      8
`define T50_NS      50000
`define T100_NS     100000
`define SETTLE_BUS  150
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10
`endif

// [rtl/bridge_ms_pkg.sv]
// Types shared by the multisampling readout block
`default_nettype none
package bridge_ms_pkg;
    // One converter result
    typedef struct packed {
        logic        valid;
        logic        invalid;
        logic        open;
        logic [15:0] data;
    } conv_in_s;
    // Converter setup towards the analog front end
    typedef struct packed {
        logic       start;
        logic [2:0] gain;
        logic       extended;
    } conv_out_s;
    // Settling state, Gray order
    typedef enum logic [0:0] {
        SETTLE = 1'b0,
        RUN    = 1'b1
    } phase_e;
endpackage
`default_nettype wire

// [rtl/bridge_multisample_readout.sv]
// Multisampling bridge readout with AXI4-Lite registers
//
// Local design decisions: the address map and the AXI4-Lite register port.
`include "bridge_ms_cfg.svh"
`default_nettype none
module bridge_multisample_readout #(
    parameter int P50_CYC  = (`T50_NS + `CLK_NS - 1) / `CLK_NS,
    parameter int P100_CYC = (`T100_NS + `CLK_NS - 1) / `CLK_NS
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      arst_n_i,
    // AXI4-Lite slave
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // Station bus cycle start
    input  wire logic                      cycle_sync_i,
    // Converter
    input  wire bridge_ms_pkg::conv_in_s   conv_i,
    output bridge_ms_pkg::conv_out_s       conv_o,
    // Interrupt and status
    output logic                           irq_o,
    output logic [7:0]                     module_state_flags_o
);
    // ****************
    // Register storage
    // ****************
    logic [7:0]  range_ff, nxt_range;
    logic [7:0]  period_ff, nxt_period;
    logic [3:0]  count_ff, nxt_count;
    logic [2:0]  irq_st_ff, nxt_irq_st;
    logic [2:0]  irq_msk_ff, nxt_irq_msk;
    logic [7:0]  flags_ff, nxt_flags;
    logic [15:0] smp_ff [10];
    logic [15:0] nxt_smp [10];
    logic [15:0] work_ff [10];
    logic [15:0] nxt_work [10];

    // ****************
    // Bus slave
    // ****************
    logic        aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
    logic [7:0]  awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd;
    logic [3:0]  ws_ff, nxt_ws;
    logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
    logic [31:0] rd_ff, nxt_rd;
    logic        wr_go, rd_go, wr_hit, rd_hit;
    logic [31:0] rd_val;

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'b00 && a <= `ADR_IRQ_MSK;
    endfunction

    assign s_axi_awready = !aw_ff && !bv_ff;
    assign s_axi_wready  = !w_ff && !bv_ff;
    assign s_axi_arready = !rv_ff;
    assign s_axi_bvalid  = bv_ff;
    assign s_axi_bresp   = br_ff;
    assign s_axi_rvalid  = rv_ff;
    assign s_axi_rresp   = rr_ff;
    assign s_axi_rdata   = rd_ff;
    assign wr_go  = aw_ff && w_ff && !bv_ff;
    assign rd_go  = s_axi_arvalid && !rv_ff;
    assign wr_hit = wr_go && mapped(awa_ff) && ws_ff[0];
    assign rd_hit = rd_go && mapped(s_axi_araddr);

    always_comb begin
        rd_val = 32'h0000_0000;
        if (s_axi_araddr >= `ADR_SMP1 && s_axi_araddr <= `ADR_SMP10) begin
            rd_val = {16'h0000, smp_ff[4'((s_axi_araddr - `ADR_SMP1) >> 2)]};
        end
        unique case (s_axi_araddr)
            `ADR_FLAGS:   rd_val = {24'h00_0000, flags_ff};
            `ADR_RANGE:   rd_val = {24'h00_0000, range_ff};
            `ADR_PERIOD:  rd_val = {24'h00_0000, period_ff};
            `ADR_COUNT:   rd_val = {28'h000_0000, count_ff};
            `ADR_IRQ_ST:  rd_val = {29'h0000_0000, irq_st_ff};
            `ADR_IRQ_MSK: rd_val = {29'h0000_0000, irq_msk_ff};
            default: ;
        endcase
    end

    always_comb begin
        nxt_aw  = aw_ff;
        nxt_w   = w_ff;
        nxt_awa = awa_ff;
        nxt_wd  = wd_ff;
        nxt_ws  = ws_ff;
        nxt_bv  = bv_ff;
        nxt_br  = br_ff;
        nxt_rv  = rv_ff;
        nxt_rr  = rr_ff;
        nxt_rd  = rd_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw  = 1'b1;
            nxt_awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w  = 1'b1;
            nxt_wd = s_axi_wdata;
            nxt_ws = s_axi_wstrb;
        end
        if (wr_go) begin
            nxt_aw = 1'b0;
            nxt_w  = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = mapped(awa_ff) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bv_ff && s_axi_bready) begin
            nxt_bv = 1'b0;
        end
        if (rd_go) begin
            nxt_rv = 1'b1;
            nxt_rr = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            nxt_rd = rd_hit ? rd_val : 32'h0000_0000;
        end else if (rv_ff && s_axi_rready) begin
            nxt_rv = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_ff  <= 1'b0;
            w_ff   <= 1'b0;
            awa_ff <= 8'h00;
            wd_ff  <= 32'h0000_0000;
            ws_ff  <= 4'h0;
            bv_ff  <= 1'b0;
            br_ff  <= `RESP_OKAY;
            rv_ff  <= 1'b0;
            rr_ff  <= `RESP_OKAY;
            rd_ff  <= 32'h0000_0000;
        end else begin
            aw_ff  <= nxt_aw;
            w_ff   <= nxt_w;
            awa_ff <= nxt_awa;
            wd_ff  <= nxt_wd;
            ws_ff  <= nxt_ws;
            bv_ff  <= nxt_bv;
            br_ff  <= nxt_br;
            rv_ff  <= nxt_rv;
            rr_ff  <= nxt_rr;
            rd_ff  <= nxt_rd;
        end
    end

    // ****************
    // Converter timing
    // ****************
    logic [13:0]          tmr_ff, nxt_tmr;
    logic [13:0]          per_len;
    logic                 per_bad;
    logic                 mis_ff, nxt_mis;
    logic [7:0]           settle_ff, nxt_settle;
    bridge_ms_pkg::phase_e phase_ff, nxt_phase;
    logic                 start;

    assign per_bad = period_ff > `PER_100US;
    assign per_len = (period_ff == `PER_100US) ? 14'(P100_CYC - 1) : 14'(P50_CYC - 1);
    assign start = cycle_sync_i || tmr_ff == 14'h0000;

    always_comb begin
        nxt_tmr    = start ? per_len : 14'(tmr_ff - 14'h0001);
        nxt_mis    = mis_ff;
        nxt_settle = settle_ff;
        nxt_phase  = phase_ff;
        if (cycle_sync_i) begin
            // alignment check at bus cycle start
            nxt_mis = tmr_ff != 14'h0000;
            if (settle_ff != 8'h00) begin
                nxt_settle = 8'(settle_ff - 8'h01);
            end
        end
        if (wr_hit && awa_ff == `ADR_PERIOD && wd_ff[7:0] != period_ff) begin
            nxt_settle = 8'(`SETTLE_BUS);
        end
        unique case (phase_ff)
            bridge_ms_pkg::SETTLE: if (nxt_settle == 8'h00) nxt_phase = bridge_ms_pkg::RUN;
            bridge_ms_pkg::RUN:    if (nxt_settle != 8'h00) nxt_phase = bridge_ms_pkg::SETTLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tmr_ff    <= 14'h0000;
            mis_ff    <= 1'b1;
            settle_ff <= 8'(`SETTLE_BUS);
            phase_ff  <= bridge_ms_pkg::SETTLE;
        end else begin
            tmr_ff    <= nxt_tmr;
            mis_ff    <= nxt_mis;
            settle_ff <= nxt_settle;
            phase_ff  <= nxt_phase;
        end
    end

    // ****************
    // Sample collection
    // ****************
    logic [3:0] n_ff, nxt_n;
    logic       c_open_ff, nxt_c_open, c_bad_ff, nxt_c_bad;
    logic       nsync;
    logic       take;

    // no more than the configured count, ten at most
    assign take  = conv_i.valid && !cycle_sync_i && n_ff < count_ff;
    assign nsync = phase_ff == bridge_ms_pkg::SETTLE || per_bad || mis_ff;

    always_comb begin
        nxt_n      = n_ff;
        nxt_c_open = c_open_ff;
        nxt_c_bad  = c_bad_ff;
        nxt_work   = work_ff;
        nxt_smp    = smp_ff;
        nxt_flags  = flags_ff;
        if (take) begin
            nxt_work[n_ff] = conv_i.data;
            nxt_n          = 4'(n_ff + 4'h1);
            nxt_c_open     = c_open_ff || conv_i.open;
            nxt_c_bad      = c_bad_ff || conv_i.invalid;
        end
        if (cycle_sync_i) begin
            nxt_smp    = work_ff;
            // invalid if any bad or none taken
            nxt_flags[`BIT_INVALID] = c_bad_ff || n_ff == 4'h0;
            // open bit follows this cycle only
            nxt_flags[`BIT_OPEN]    = c_open_ff;
            nxt_n      = 4'h0;
            nxt_c_open = 1'b0;
            nxt_c_bad  = 1'b0;
        end
        nxt_flags[`BIT_NSYNC] = nsync;
        nxt_flags[7:3] = 5'h00;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            n_ff      <= 4'h0;
            c_open_ff <= 1'b0;
            c_bad_ff  <= 1'b0;
            flags_ff  <= 8'h01;
            for (int i = 0; i < 10; i++) begin
                work_ff[i] <= 16'h0000;
                smp_ff[i]  <= 16'h0000;
            end
        end else begin
            n_ff      <= nxt_n;
            c_open_ff <= nxt_c_open;
            c_bad_ff  <= nxt_c_bad;
            flags_ff  <= nxt_flags;
            work_ff   <= nxt_work;
            smp_ff    <= nxt_smp;
        end
    end

    // ****************
    // Control and interrupt registers
    // ****************
    logic [2:0] ev;
    logic       nsync_d_ff;

    assign ev = {nsync && !nsync_d_ff, cycle_sync_i && c_open_ff, cycle_sync_i};

    always_comb begin
        nxt_range   = range_ff;
        nxt_period  = period_ff;
        nxt_count   = count_ff;
        nxt_irq_msk = irq_msk_ff;
        nxt_irq_st  = irq_st_ff;
        if (wr_hit) begin
            unique case (awa_ff)
                `ADR_RANGE:   nxt_range   = {5'h00, wd_ff[2:0]};
                `ADR_PERIOD:  nxt_period  = wd_ff[7:0];
                `ADR_COUNT:   nxt_count   = (wd_ff[3:0] < `COUNT_MIN) ? `COUNT_MIN :
                                            (wd_ff[3:0] > `COUNT_MAX) ? `COUNT_MAX : wd_ff[3:0];
                `ADR_IRQ_MSK: nxt_irq_msk = wd_ff[2:0];
                default: ;
            endcase
        end
        if (rd_hit && s_axi_araddr == `ADR_IRQ_ST) begin
            nxt_irq_st = 3'h0;
        end
        nxt_irq_st = nxt_irq_st | ev;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            range_ff   <= `RANGE_RST;
            period_ff  <= `PERIOD_RST;
            count_ff   <= `COUNT_RST;
            irq_msk_ff <= 3'h0;
            irq_st_ff  <= 3'h0;
            nsync_d_ff <= 1'b1;
        end else begin
            range_ff   <= nxt_range;
            period_ff  <= nxt_period;
            count_ff   <= nxt_count;
            irq_msk_ff <= nxt_irq_msk;
            irq_st_ff  <= nxt_irq_st;
            nsync_d_ff <= nsync;
        end
    end

    // ****************
    // Outputs
    // ****************
    assign irq_o                = |(irq_st_ff & irq_msk_ff);
    assign module_state_flags_o = flags_ff;
    assign conv_o.start    = start;
    assign conv_o.gain     = range_ff[2:0];
    assign conv_o.extended = range_ff[2];

    // ****************
    // Assertions
    // ****************
    a_open_sets: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cycle_sync_i && c_open_ff |=> flags_ff[`BIT_OPEN])
        else $error("open bit not set");
    a_open_clears: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cycle_sync_i && !c_open_ff |=> !flags_ff[`BIT_OPEN])
        else $error("open bit not cleared");
    a_invalid_none: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cycle_sync_i && n_ff == 4'h0 |=> flags_ff[`BIT_INVALID])
        else $error("empty cycle not invalid");
    a_nsync_settle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        settle_ff != 8'h00 |=> flags_ff[`BIT_NSYNC])
        else $error("settling not flagged");
    a_nsync_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !nsync |=> !flags_ff[`BIT_NSYNC])
        else $error("sync bit stuck");
    a_count_cap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        n_ff <= `COUNT_MAX && count_ff >= `COUNT_MIN && count_ff <= `COUNT_MAX)
        else $error("too many samples");
    a_period_50: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        start && !cycle_sync_i && period_ff == `PER_50US |=> tmr_ff == 14'(P50_CYC - 1))
        else $error("50 us period wrong");
    a_period_100: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        start && period_ff == `PER_100US |=> tmr_ff == 14'(P100_CYC - 1))
        else $error("100 us period wrong");
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        flags_ff[7:3] == 5'h00)
        else $error("reserved bits set");
    a_gain_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_hit && awa_ff == `ADR_RANGE |=> conv_o.gain == $past(wd_ff[2:0]))
        else $error("gain not applied");
    a_sample_latch: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cycle_sync_i |=> smp_ff[0] == $past(work_ff[0]))
        else $error("sample not latched");
endmodule
`default_nettype wire

// [verif/bridge_far_side_model.sv]
// Converter front end and station bus cycle source facing the readout
`default_nettype none
module bridge_far_side_model (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     arst_n_i,
    // Scenario controls
    input  wire logic [15:0]              bus_cyc_i,
    input  wire logic                     open_i,
    input  wire logic                     bad_i,
    // Readout side
    input  wire bridge_ms_pkg::conv_out_s setup_i,
    output bridge_ms_pkg::conv_in_s       result_o,
    output logic                          sync_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] seq_ff;
    logic [15:0] tmr_ff;
    logic [1:0]  dly_ff;
    // ********
    // Cycle source and converter
    // ********
    // fixed bus period
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {tmr_ff, sync_o, dly_ff, seq_ff, result_o} <= '0;
        end else begin
            sync_o         <= (tmr_ff == 16'h0000);
            tmr_ff         <= (tmr_ff == 16'h0000) ? bus_cyc_i - 16'h0001 : tmr_ff - 16'h0001;
            dly_ff         <= {dly_ff[0], setup_i.start};
            result_o.valid <= dly_ff[1];
            if (dly_ff[1]) begin
                result_o.data    <= seq_ff;
                result_o.invalid <= bad_i;
                result_o.open    <= open_i;
                seq_ff           <= seq_ff + 16'h0001;
            end else begin
                // Idle lines toggle so stale values never pass
                result_o.data    <= ~result_o.data;
                result_o.invalid <= ~result_o.invalid;
                result_o.open    <= ~result_o.open;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/bridge_multisample_readout_test.sv]
// Self-checking bench for the multisampling bridge readout
`include "bridge_ms_cfg.svh"
`default_nettype none
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: %s", $time, m); end end
module bridge_multisample_readout_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P50 = 10;
    logic        clk_i, arst_n_i, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, sync, irq, open_req, bad_req;
    logic [7:0]  awaddr, araddr, flags;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] bus_cyc;
    int          tests_run, failures;
    bridge_ms_pkg::conv_in_s  conv_in;
    bridge_ms_pkg::conv_out_s conv_out;
    bridge_multisample_readout #(.P50_CYC(P50), .P100_CYC(2 * P50)) uut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cycle_sync_i(sync), .conv_i(conv_in), .conv_o(conv_out), .irq_o(irq),
        .module_state_flags_o(flags));
    bridge_far_side_model far (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .bus_cyc_i(bus_cyc), .open_i(open_req),
        .bad_i(bad_req), .setup_i(conv_out), .result_o(conv_in), .sync_o(sync));
    // ********
    // Bus and timing tasks
    // ********
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic over();
        failures++;
        $display("wrong value at %0t: wait ran out", $time);
        wrap_up();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int   n;
        logic ta, tw, tb;
        @(posedge clk_i);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'b111;
        for (n = 0; n < 50; n++) begin
            @(negedge clk_i);
            {ta, tw, tb} = {awready & awvalid, wready & wvalid, bvalid};
            if (tb) `CHK(bresp, er, "write resp")
            @(posedge clk_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
        if (n == 50) over();
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int   n;
        logic ta, tr;
        @(posedge clk_i);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (n = 0; n < 50; n++) begin
            @(negedge clk_i);
            {ta, tr, d} = {arready & arvalid, rvalid, rdata};
            if (tr) `CHK(rresp, er, "read resp")
            @(posedge clk_i);
            if (ta) arvalid <= 1'b0;
            if (tr) break;
        end
        rready <= 1'b0;
        if (n == 50) over();
    endtask
    task automatic exp_rd(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] d;
        rd(a, `RESP_OKAY, d);
        `CHK(d, e, m)
    endtask
    task automatic syncs(input int k);
        int n;
        for (n = 0; n < 100000 && k > 0; n++) begin
            @(negedge clk_i);
            if (sync) k--;
        end
        if (k > 0) over();
        repeat (3) @(posedge clk_i);
    endtask
    task automatic gap(input int e, input string m);
        int c;
        c = 0;
        do begin
            @(negedge clk_i);
            c++;
        end while (c < 200 && sync !== 1'b1);
        c = 0;
        do begin
            @(negedge clk_i);
            c++;
        end while (c < 200 && conv_out.start !== 1'b1);
        `CHK(c, e, m)
        @(posedge clk_i);
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        logic [31:0] d;
        exp_rd(`ADR_FLAGS, 32'h05, "flags after reset");
        exp_rd(`ADR_PERIOD, {24'h0, `PERIOD_RST}, "period reset");
        exp_rd(`ADR_RANGE, {24'h0, `RANGE_RST}, "range reset");
        exp_rd(`ADR_COUNT, {28'h0, `COUNT_RST}, "count reset");
        rd(8'h40, `RESP_SLVERR, d);
        `CHK(d, 32'h0, "unmapped data")
        wr(8'h40, 32'h1, 4'hf, `RESP_SLVERR);
        $display("test reset done");
    endtask
    task automatic t_settle();
        logic [31:0] d;
        syncs(100);
        rd(`ADR_FLAGS, `RESP_OKAY, d);
        `CHK(d[2], 1'b1, "settling")
        syncs(55);
        exp_rd(`ADR_FLAGS, 32'h0, "settled");
        $display("test settle done");
    endtask
    task automatic t_samples();
        logic [31:0] s [1:5];
        wr(`ADR_COUNT, 32'h1, 4'hf, `RESP_OKAY);
        exp_rd(`ADR_COUNT, {28'h0, `COUNT_MIN}, "count low clamp");
        wr(`ADR_COUNT, 32'hf, 4'hf, `RESP_OKAY);
        exp_rd(`ADR_COUNT, {28'h0, `COUNT_MAX}, "count high clamp");
        wr(`ADR_COUNT, 32'h5, 4'hf, `RESP_OKAY);
        syncs(2);
        for (int k = 1; k <= 5; k++) rd(`ADR_SMP1 + 8'(4 * k - 4), `RESP_OKAY, s[k]);
        for (int k = 2; k <= 5; k++) `CHK(s[k], s[k - 1] + 32'h1, "sample order")
        `CHK(s[1][31:16], 16'h0, "sample width")
        $display("test samples done");
    endtask
    task automatic t_gain();
        for (int g = 0; g < 8; g++) begin
            wr(`ADR_RANGE, 32'(g), 4'hf, `RESP_OKAY);
            exp_rd(`ADR_RANGE, 32'(g), "range readback");
            `CHK({conv_out.extended, conv_out.gain}, {g[2], g[2:0]}, "gain pins")
        end
        wr(`ADR_RANGE, 32'hfd, 4'hf, `RESP_OKAY);
        wr(`ADR_RANGE, 32'h02, 4'h0, `RESP_OKAY);
        exp_rd(`ADR_RANGE, 32'h5, "range low bits");
        wr(`ADR_RANGE, 32'h0, 4'hf, `RESP_OKAY);
        $display("test gain done");
    endtask
    task automatic t_faults();
        logic [31:0] d;
        wr(`ADR_IRQ_MSK, 32'h2, 4'hf, `RESP_OKAY);
        rd(`ADR_IRQ_ST, `RESP_OKAY, d);
        open_req <= 1'b1;
        syncs(2);
        exp_rd(`ADR_FLAGS, 32'h2, "open set");
        `CHK(irq, 1'b1, "open irq")
        exp_rd(`ADR_IRQ_ST, 32'h3, "irq status");
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0, "read clears")
        open_req <= 1'b0;
        bad_req <= 1'b1;
        syncs(2);
        exp_rd(`ADR_FLAGS, 32'h1, "open clears, invalid set");
        bad_req <= 1'b0;
        syncs(2);
        exp_rd(`ADR_FLAGS, 32'h0, "invalid clears");
        wr(`ADR_FLAGS, 32'hff, 4'hf, `RESP_OKAY);
        exp_rd(`ADR_FLAGS, 32'h0, "read-only flags");
        wr(`ADR_IRQ_MSK, 32'h1, 4'hf, `RESP_OKAY);
        rd(`ADR_IRQ_ST, `RESP_OKAY, d);
        syncs(1);
        `CHK(irq, 1'b1, "data irq")
        wr(`ADR_IRQ_MSK, 32'h0, 4'hf, `RESP_OKAY);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0, "masked irq")
        $display("test faults done");
    endtask
    task automatic t_period();
        logic [31:0] d;
        wr(`ADR_PERIOD, {24'h0, `PER_100US}, 4'hf, `RESP_OKAY);
        exp_rd(`ADR_PERIOD, 32'h1, "period readback");
        gap(2 * P50, "interval 100");
        rd(`ADR_IRQ_ST, `RESP_OKAY, d);
        `CHK(d[2], 1'b1, "not-sync event")
        syncs(3);
        rd(`ADR_FLAGS, `RESP_OKAY, d);
        `CHK(d[2], 1'b1, "resettle")
        wr(`ADR_PERIOD, 32'h2, 4'hf, `RESP_OKAY);
        exp_rd(`ADR_PERIOD, 32'h2, "reserved period");
        gap(P50, "interval 50");
        $display("test period done");
    endtask
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        {arst_n_i, awvalid, wvalid, bready, arvalid, rready, open_req, bad_req} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        bus_cyc = 16'(5 * P50);
        tests_run = 0;
        failures = 0;
        repeat (8) @(posedge clk_i);
        `CHK(flags, 8'h01, "flags in reset")
        arst_n_i <= 1'b1;
        t_reset();
        t_settle();
        t_samples();
        t_gain();
        t_faults();
        t_period();
        wrap_up();
    end
endmodule
`default_nettype wire
